// File: verilog/dis_pkg.sv
/*
 * Constants for the drive input select and frequency skip block:
 * register offsets, reset values, codes and time base.
 * Assumes a 250 MHz system clock and 0.01 Hz frequency units.
 */
package dis_pkg;
    // Register offsets (word addresses on the plain register port)
    localparam logic [4:0] DIS_REG_JUMP_EN = 5'h00;
    localparam logic [4:0] DIS_REG_B1_LO = 5'h01;
    localparam logic [4:0] DIS_REG_B1_HI = 5'h02;
    localparam logic [4:0] DIS_REG_B2_LO = 5'h03;
    localparam logic [4:0] DIS_REG_B2_HI = 5'h04;
    localparam logic [4:0] DIS_REG_B3_LO = 5'h05;
    localparam logic [4:0] DIS_REG_B3_HI = 5'h06;
    localparam logic [4:0] DIS_REG_ALT_RUN = 5'h07;
    localparam logic [4:0] DIS_REG_ALT_SPD = 5'h08;
    localparam logic [4:0] DIS_REG_ON_TIME = 5'h09;
    localparam logic [4:0] DIS_REG_OFF_TIME = 5'h0a;
    localparam logic [4:0] DIS_REG_POLARITY = 5'h0b;
    localparam logic [4:0] DIS_REG_STATE = 5'h0c;
    localparam logic [4:0] DIS_REG_DLY_SEL = 5'h0d;
    localparam logic [4:0] DIS_REG_FUNC0 = 5'h10;
    localparam logic [4:0] DIS_REG_MAX_FREQ = 5'h15;
    localparam logic [4:0] DIS_REG_STATUS = 5'h16;
    // Reset values, frequencies in 0.01 Hz
    localparam logic [15:0] DIS_RST_B1_LO = 16'h03e8;
    localparam logic [15:0] DIS_RST_B1_HI = 16'h05dc;
    localparam logic [15:0] DIS_RST_B2_LO = 16'h07d0;
    localparam logic [15:0] DIS_RST_B2_HI = 16'h09c4;
    localparam logic [15:0] DIS_RST_B3_LO = 16'h0bb8;
    localparam logic [15:0] DIS_RST_B3_HI = 16'h0dac;
    localparam logic [15:0] DIS_RST_MAX_FREQ = 16'h1770;
    localparam logic [15:0] DIS_RST_ON_TIME = 16'h000a;
    localparam logic [15:0] DIS_RST_OFF_TIME = 16'h0003;
    localparam logic [15:0] DIS_MAX_FILTER_MS = 16'h2710;
    localparam logic [7:0] DIS_RST_ALT_RUN = 8'h00;
    localparam logic [7:0] DIS_RST_ALT_SPD = 8'h00;
    localparam logic [7:0] DIS_MAX_ALT_RUN = 8'h04;
    localparam logic [7:0] DIS_MAX_ALT_SPD = 8'h0c;
    localparam logic [7:0] DIS_MAX_FUNC = 8'h36;
    localparam logic [7:0] DIS_FUNC_ALT_SELECT = 8'h0f;
    localparam logic [7:0] DIS_RST_FUNC = 8'h00;
    localparam logic [4:0] DIS_RST_POLARITY = 5'h00;
    localparam logic [4:0] DIS_RST_DLY_SEL = 5'h00;
    // Time base: 1 ms tick from the system clock
    localparam int DIS_CLK_MHZ = 250;
    localparam int DIS_TICK_US = 1000;
    localparam int DIS_TICK_CYCLES = DIS_CLK_MHZ * DIS_TICK_US;
    localparam int DIS_TERMINALS = 5;
endpackage

// File: verilog/dis_input_jump.sv
/*
 * Digital input conditioning, alternate source select and frequency
 * skip bands for a motor drive front end.
 * Assumes raw terminal levels are asynchronous contacts and that the
 * register port master follows a one-cycle strobe protocol.
 */
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps

// Overview of operation
// - Rising request in band holds band floor
// - Request above band resumes following
// - Output never settles inside enabled band
// - Three bands, band one 10 to 15 Hz
// - Bands two, three defaults; limits ordered
// - Function code 15 selects alternate sources
// - Alternate asserted uses alternate sources
// - Alternate switch replaces reference and run
// - Alternate settings locked under primary source
// - Alternate codes 0-4 and 0-12, default 0
// - Mode switch may stop the motor
// - On change accepted after stable delay
// - Separate off delay, default 3 ms
// - Select bit picks default or programmed times
// - Five contact polarity bits, default open
// - Status inverted for normally closed
module dis_input_jump
    import dis_pkg::*;
#(
    parameter int TICK_CYCLES = DIS_TICK_CYCLES
) (
    input wire logic ref_clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [4:0] reg_addr, // Register word address
    input wire logic [15:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [4:0] terminal_raw, // Raw contact levels
    input wire logic [7:0] primary_run_origin, // Primary command code
    input wire logic [7:0] primary_speed_origin, // Primary reference code
    input wire logic primary_run_request, // Run request, primary
    input wire logic secondary_run_request, // Run request, secondary
    input wire logic [15:0] primary_speed, // Primary reference, 0.01 Hz
    input wire logic [15:0] secondary_speed, // Secondary reference
    output logic [7:0] run_origin, // Selected command code
    output logic [7:0] speed_origin, // Selected reference code
    output logic run_command, // Selected run request
    output logic run_stop_event, // Pulse: switch dropped run
    output logic alternate_origin_select, // Alternate sources active
    output logic [4:0] terminal_state_bits, // Debounced terminal state
    output logic [15:0] output_speed // Skip-filtered frequency
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    // Software-visible settings
    logic jump_enable;
    logic [15:0] band_floor [3];
    logic [15:0] band_ceiling [3];
    logic [15:0] max_freq;
    logic [7:0] alternate_run_origin;
    logic [7:0] alternate_speed_origin;
    logic [15:0] rise_debounce_time;
    logic [15:0] fall_debounce_time;
    logic [4:0] contact_polarity_bits;
    logic [4:0] debounce_source_bits;
    logic [7:0] terminal_function_code [DIS_TERMINALS];
    logic write_refused;

    // Internal state
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [4:0] raw_meta;
    logic [4:0] raw_sync;
    logic [4:0] active_level;
    logic [15:0] stable_ms [DIS_TERMINALS];
    logic [15:0] limit_lo;
    logic [15:0] limit_hi;
    logic [15:0] held_speed;
    logic [15:0] selected_speed;
    logic alt_active;
    logic next_alt_active;
    logic [15:0] limit_unused;

    // Write legality: ordered bands, capped codes and times
    logic wr_ok;
    logic [1:0] band_idx;
    always_comb begin
        band_idx = 2'((reg_addr - DIS_REG_B1_LO) >> 1);
        wr_ok = 1'b1;
        limit_lo = band_floor[band_idx];
        limit_hi = band_ceiling[band_idx];
        case (reg_addr)
            DIS_REG_B1_LO, DIS_REG_B2_LO, DIS_REG_B3_LO:
                wr_ok = reg_wdata <= limit_hi;
            DIS_REG_B1_HI, DIS_REG_B2_HI, DIS_REG_B3_HI:
                wr_ok = reg_wdata >= limit_lo && reg_wdata <= max_freq;
            DIS_REG_ALT_RUN:
                wr_ok = alt_active && reg_wdata[7:0] <= DIS_MAX_ALT_RUN
                    && reg_wdata[15:8] == 8'h00;
            DIS_REG_ALT_SPD:
                wr_ok = alt_active && reg_wdata[7:0] <= DIS_MAX_ALT_SPD
                    && reg_wdata[15:8] == 8'h00;
            DIS_REG_ON_TIME, DIS_REG_OFF_TIME:
                wr_ok = reg_wdata <= DIS_MAX_FILTER_MS;
            DIS_REG_MAX_FREQ:
                wr_ok = reg_wdata >= band_ceiling[2]
                    && reg_wdata >= band_ceiling[1]
                    && reg_wdata >= band_ceiling[0];
            default:
                wr_ok = 1'b1;
        endcase
        if (reg_addr >= DIS_REG_FUNC0
            && reg_addr < DIS_REG_FUNC0 + 5'(DIS_TERMINALS))
            wr_ok = reg_wdata <= 16'(DIS_MAX_FUNC);
    end

    // Register writes; illegal writes leave the old value
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            jump_enable <= 1'b0;
            band_floor[0] <= DIS_RST_B1_LO;
            band_ceiling[0] <= DIS_RST_B1_HI;
            band_floor[1] <= DIS_RST_B2_LO;
            band_ceiling[1] <= DIS_RST_B2_HI;
            band_floor[2] <= DIS_RST_B3_LO;
            band_ceiling[2] <= DIS_RST_B3_HI;
            max_freq <= DIS_RST_MAX_FREQ;
            alternate_run_origin <= DIS_RST_ALT_RUN;
            alternate_speed_origin <= DIS_RST_ALT_SPD;
            rise_debounce_time <= DIS_RST_ON_TIME;
            fall_debounce_time <= DIS_RST_OFF_TIME;
            contact_polarity_bits <= DIS_RST_POLARITY;
            debounce_source_bits <= DIS_RST_DLY_SEL;
            for (int i = 0; i < DIS_TERMINALS; i++) begin
                terminal_function_code[i] <= DIS_RST_FUNC;
            end
            write_refused <= 1'b0;
        end else if (reg_wr) begin
            write_refused <= !wr_ok;
            if (wr_ok) begin
                case (reg_addr)
                    DIS_REG_JUMP_EN: jump_enable <= reg_wdata[0];
                    DIS_REG_B1_LO: band_floor[0] <= reg_wdata;
                    DIS_REG_B1_HI: band_ceiling[0] <= reg_wdata;
                    DIS_REG_B2_LO: band_floor[1] <= reg_wdata;
                    DIS_REG_B2_HI: band_ceiling[1] <= reg_wdata;
                    DIS_REG_B3_LO: band_floor[2] <= reg_wdata;
                    DIS_REG_B3_HI: band_ceiling[2] <= reg_wdata;
                    DIS_REG_MAX_FREQ: max_freq <= reg_wdata;
                    DIS_REG_ALT_RUN: alternate_run_origin <= reg_wdata[7:0];
                    DIS_REG_ALT_SPD:
                        alternate_speed_origin <= reg_wdata[7:0];
                    DIS_REG_ON_TIME: rise_debounce_time <= reg_wdata;
                    DIS_REG_OFF_TIME: fall_debounce_time <= reg_wdata;
                    DIS_REG_POLARITY: contact_polarity_bits <= reg_wdata[4:0];
                    DIS_REG_DLY_SEL: debounce_source_bits <= reg_wdata[4:0];
                    default: begin
                        for (int i = 0; i < DIS_TERMINALS; i++) begin
                            if (reg_addr == DIS_REG_FUNC0 + 5'(i))
                                terminal_function_code[i] <= reg_wdata[7:0];
                        end
                    end
                endcase
            end
        end
    end

    // Read data stands for exactly the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (reg_addr)
                DIS_REG_JUMP_EN: reg_rdata <= {15'h0000, jump_enable};
                DIS_REG_B1_LO: reg_rdata <= band_floor[0];
                DIS_REG_B1_HI: reg_rdata <= band_ceiling[0];
                DIS_REG_B2_LO: reg_rdata <= band_floor[1];
                DIS_REG_B2_HI: reg_rdata <= band_ceiling[1];
                DIS_REG_B3_LO: reg_rdata <= band_floor[2];
                DIS_REG_B3_HI: reg_rdata <= band_ceiling[2];
                DIS_REG_MAX_FREQ: reg_rdata <= max_freq;
                DIS_REG_ALT_RUN: reg_rdata <= {8'h00, alternate_run_origin};
                DIS_REG_ALT_SPD:
                    reg_rdata <= {8'h00, alternate_speed_origin};
                DIS_REG_ON_TIME: reg_rdata <= rise_debounce_time;
                DIS_REG_OFF_TIME: reg_rdata <= fall_debounce_time;
                DIS_REG_POLARITY:
                    reg_rdata <= {11'h000, contact_polarity_bits};
                DIS_REG_STATE:
                    reg_rdata <= {11'h000, terminal_state_bits};
                DIS_REG_DLY_SEL:
                    reg_rdata <= {11'h000, debounce_source_bits};
                DIS_REG_STATUS:
                    reg_rdata <= {14'h0000, write_refused, alt_active};
                default: begin
                    reg_rdata <= 16'h0000;
                    for (int i = 0; i < DIS_TERMINALS; i++) begin
                        if (reg_addr == DIS_REG_FUNC0 + 5'(i))
                            reg_rdata <= {8'h00, terminal_function_code[i]};
                    end
                end
            endcase
        end
    end

    // Millisecond time base for the input filters
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // Contacts are asynchronous, so two flops before any use
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            raw_meta <= 5'h00;
            raw_sync <= 5'h00;
        end else begin
            raw_meta <= terminal_raw;
            raw_sync <= raw_meta;
        end
    end

    // Polarity: a closed-contact terminal reads active when open
    assign active_level = raw_sync ^ contact_polarity_bits;

    // Debounce: new level accepted once stable for the chosen time
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            terminal_state_bits <= 5'h00;
            for (int i = 0; i < DIS_TERMINALS; i++) begin
                stable_ms[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < DIS_TERMINALS; i++) begin
                automatic logic [15:0] need;
                need = active_level[i]
                    ? (debounce_source_bits[i] ? rise_debounce_time
                                               : DIS_RST_ON_TIME)
                    : (debounce_source_bits[i] ? fall_debounce_time
                                               : DIS_RST_OFF_TIME);
                if (active_level[i] == terminal_state_bits[i]) begin
                    stable_ms[i] <= 16'h0000;
                end else if (stable_ms[i] >= need) begin
                    terminal_state_bits[i] <= active_level[i];
                    stable_ms[i] <= 16'h0000;
                end else if (tick) begin
                    stable_ms[i] <= stable_ms[i] + 16'h0001;
                end
            end
        end
    end

    // Any terminal coded as alternate select drives the switch
    always_comb begin
        next_alt_active = 1'b0;
        for (int i = 0; i < DIS_TERMINALS; i++) begin
            if (terminal_function_code[i] == DIS_FUNC_ALT_SELECT
                && terminal_state_bits[i])
                next_alt_active = 1'b1;
        end
    end

    // Source selection switches reference and run together
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alt_active <= 1'b0;
            run_origin <= 8'h00;
            speed_origin <= 8'h00;
            run_command <= 1'b0;
            selected_speed <= 16'h0000;
            run_stop_event <= 1'b0;
        end else begin
            alt_active <= next_alt_active;
            if (next_alt_active) begin
                run_origin <= alternate_run_origin;
                speed_origin <= alternate_speed_origin;
                run_command <= secondary_run_request;
                selected_speed <= secondary_speed;
            end else begin
                run_origin <= primary_run_origin;
                speed_origin <= primary_speed_origin;
                run_command <= primary_run_request;
                selected_speed <= primary_speed;
            end
            // Run may drop on a mode change if the new source is idle
            // Compare the run now standing with the one about to be taken
            run_stop_event <= run_command
                && !(next_alt_active ? secondary_run_request
                                     : primary_run_request)
                && (alt_active != next_alt_active);
        end
    end
    assign alternate_origin_select = alt_active;

    // Skip bands: hold floor rising, ceiling falling, never inside
    always_comb begin
        automatic logic [15:0] f;
        f = selected_speed;
        if (jump_enable) begin
            for (int b = 0; b < 3; b++) begin
                if (f > band_floor[b] && f < band_ceiling[b]) begin
                    if (held_speed >= band_ceiling[b])
                        f = band_ceiling[b];
                    else
                        f = band_floor[b];
                end
            end
        end
        output_speed = held_speed;
        limit_unused = f;
    end

    // Output register follows the filtered request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            held_speed <= 16'h0000;
        end else begin
            held_speed <= limit_unused;
        end
    end

endmodule

// File: tb/dis_input_jump_props.sv
/*
 * Port checker for the input select and frequency skip block.
 * Assumes it is bound to dis_input_jump and sees only its ports.
 */
`timescale 1ns/100ps
module dis_input_jump_props
    import dis_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [4:0] reg_addr, // Address
    input wire logic reg_rd, // Read strobe
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic primary_run_request, // Primary run
    input wire logic secondary_run_request, // Secondary run
    input wire logic [7:0] primary_run_origin, // Primary command code
    input wire logic [7:0] primary_speed_origin, // Primary reference code
    input wire logic [7:0] run_origin, // Selected command code
    input wire logic [7:0] speed_origin, // Selected reference code
    input wire logic run_command, // Selected run
    input wire logic run_stop_event, // Stop pulse
    input wire logic alternate_origin_select, // Alternate active
    input wire logic [4:0] terminal_state_bits // Debounced state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Steps shared by the properties below
    sequence read_done;
        $past(reg_rd);
    endsequence
    sequence alt_rise;
        $rose(alternate_origin_select);
    endsequence
    sequence settled_primary;
        !alternate_origin_select && !$past(sys_rst);
    endsequence

    // Read data only stands in the cycle after a strobe
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    a_state_read: assert property (read_done ##0 $past(reg_addr) == 5'h0c |->
        reg_rdata == {11'h000, $past(terminal_state_bits)})
        else $error("state read differs from state port");
    a_unmapped_zero: assert property (read_done ##0
        $past(reg_addr) inside {5'h0e, 5'h0f, 5'h17} |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_run_primary: assert property (settled_primary |->
        run_command == $past(primary_run_request))
        else $error("run command not from primary");
    a_run_alt: assert property (alternate_origin_select && !$past(sys_rst)
        |-> run_command == $past(secondary_run_request))
        else $error("run command not from secondary");
    a_origin_primary: assert property (settled_primary |->
        run_origin == $past(primary_run_origin) &&
        speed_origin == $past(primary_speed_origin))
        else $error("source codes not from primary");
    a_alt_cause: assert property (alt_rise |->
        $past(terminal_state_bits) != 5'h00)
        else $error("alternate selected with no active terminal");
    a_stop_low: assert property (run_stop_event |-> !run_command)
        else $error("stop pulse while run still on");
    a_stop_pulse: assert property (run_stop_event |=> !run_stop_event)
        else $error("stop pulse longer than one cycle");
    c_alt_rise: cover property (alt_rise);
endmodule

bind dis_input_jump dis_input_jump_props dis_input_jump_props_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .primary_run_request(primary_run_request),
    .secondary_run_request(secondary_run_request),
    .primary_run_origin(primary_run_origin),
    .primary_speed_origin(primary_speed_origin),
    .run_origin(run_origin), .speed_origin(speed_origin),
    .run_command(run_command), .run_stop_event(run_stop_event),
    .alternate_origin_select(alternate_origin_select),
    .terminal_state_bits(terminal_state_bits)
);

// File: tb/dis_contacts.sv
/*
 * Contact switch model for the five input terminals.
 * Assumes the bench sets settled levels and chatter masks.
 */
`timescale 1ns/100ps
module dis_contacts (
    input wire logic ref_clk, // Clock
    input wire logic [4:0] target, // Settled contact levels
    input wire logic [4:0] glitch, // Terminals forced to chatter
    output logic [4:0] terminal_raw // Levels seen at the terminals
);
    logic [4:0] last = 5'h00;
    logic [4:0] moved = 5'h00;
    logic [1:0] bounce = 2'h0;
    initial terminal_raw = 5'h00;
    // A moving contact chatters before settling, so no clean edges
    always @(posedge ref_clk) begin
        last <= target;
        if (target != last) begin
            bounce <= 2'h3;
            moved <= target ^ last;
        end else if (bounce != 2'h0) begin
            bounce <= bounce - 2'h1;
        end
        terminal_raw <= target ^ glitch ^ (bounce[0] ? moved : 5'h00);
    end
endmodule

// File: tb/dis_input_jump_tb.sv
/*
 * Self-checking bench for the input select and frequency skip block.
 * Assumes a shortened 1 ms tick of ten clock cycles.
 */
`timescale 1ns/100ps
module dis_input_jump_tb
    import dis_pkg::*;
;
    localparam int TICK = 10;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00, target = 5'h00, glitch = 5'h00;
    logic [4:0] terminal_raw, terminal_state_bits;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, output_speed;
    logic [15:0] primary_speed = 16'h0000, secondary_speed = 16'h0fa0;
    logic [7:0] primary_run_origin = 8'h01, primary_speed_origin = 8'h02;
    logic [7:0] run_origin, speed_origin;
    logic primary_run_request = 1'b1, secondary_run_request = 1'b0;
    logic run_command, run_stop_event, alternate_origin_select;
    int mismatches = 0, total_checks = 0, stop_seen = 0, n, prev_exp = 0;
    int lo[3] = '{1000, 2000, 3000}, hi[3] = '{1500, 2500, 3500};
    int sp[7] = '{900, 1200, 1600, 1200, 900, 1000, 3200};
    bit jump_on = 1'b0;
    logic [4:0] ra[13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
        5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h15};
    logic [15:0] rv[13] = '{16'h0000, DIS_RST_B1_LO, DIS_RST_B1_HI,
        DIS_RST_B2_LO, DIS_RST_B2_HI, DIS_RST_B3_LO, DIS_RST_B3_HI, 16'h0000,
        16'h0000, 16'h000a, 16'h0003, 16'h0000, 16'h1770};

    dis_input_jump #(.TICK_CYCLES(TICK)) dis_input_jump_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .terminal_raw(terminal_raw),
        .primary_run_origin(primary_run_origin),
        .primary_speed_origin(primary_speed_origin),
        .primary_run_request(primary_run_request),
        .secondary_run_request(secondary_run_request),
        .primary_speed(primary_speed), .secondary_speed(secondary_speed),
        .run_origin(run_origin), .speed_origin(speed_origin),
        .run_command(run_command), .run_stop_event(run_stop_event),
        .alternate_origin_select(alternate_origin_select),
        .terminal_state_bits(terminal_state_bits),
        .output_speed(output_speed));
    dis_contacts dis_contacts_inst (.ref_clk(ref_clk), .target(target),
        .glitch(glitch), .terminal_raw(terminal_raw));

    // Free-running 250 MHz clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // Counts stop pulses; they last a single cycle
    always @(posedge ref_clk) begin
        if (run_stop_event === 1'b1) stop_seen++;
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data is looked at in its only valid cycle
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 cmp16(reg_rdata, exp);
    endtask
    // Reference skip model: hold floor rising, ceiling falling
    function automatic int skip(input int req);
        int r = req;
        if (jump_on)
            for (int b = 0; b < 3; b++)
                if (req > lo[b] && req < hi[b])
                    r = (prev_exp >= hi[b]) ? hi[b] : lo[b];
        return r;
    endfunction
    task automatic speed(input int v);
        @(posedge ref_clk);
        primary_speed <= v[15:0];
        repeat (3) @(posedge ref_clk);
        #1 prev_exp = skip(v);
        cmp16(output_speed, prev_exp[15:0]);
    endtask
    task automatic wait_alt(input logic lvl);
        for (n = 0; n < 400 && alternate_origin_select !== lvl; n++)
            @(posedge ref_clk);
        #1 cmp16({15'h0000, alternate_origin_select}, {15'h0000, lvl});
    endtask

    // Hang guard, far beyond the several hundred cycles needed
    initial begin
        #(30000 * 4);
        mismatches++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h18f5006e));
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(5'h0e, 16'h0000);
        speed(1200);
        wr(DIS_REG_JUMP_EN, 16'h0001);
        jump_on = 1'b1;
        foreach (sp[i]) speed(sp[i]);
        for (int i = 0; i < 16; i++) speed($urandom_range(6000, 0));
        wr(DIS_REG_B1_LO, 16'h07d0);
        rd(DIS_REG_B1_LO, DIS_RST_B1_LO);
        rd(DIS_REG_STATUS, 16'h0002);
        wr(DIS_REG_B3_HI, 16'h1771);
        rd(DIS_REG_B3_HI, DIS_RST_B3_HI);
        wr(DIS_REG_ALT_RUN, 16'h0002);
        rd(DIS_REG_ALT_RUN, 16'h0000);
        wr(5'h11, 16'h0037);
        rd(5'h11, 16'h0000);
        wr(DIS_REG_FUNC0, 16'h000f);
        target[0] <= 1'b1;
        wait_alt(1'b1);
        cmp16({15'h0000, n >= 9 * TICK}, 16'h0001);
        repeat (3) @(posedge ref_clk);
        #1 cmp16({15'h0000, run_command}, 16'h0000);
        cmp16(output_speed, 16'h0fa0);
        cmp16(stop_seen[15:0], 16'h0001);
        wr(DIS_REG_ALT_RUN, 16'h0004);
        wr(DIS_REG_ALT_RUN, 16'h0005);
        rd(DIS_REG_ALT_RUN, 16'h0004);
        wr(DIS_REG_ALT_SPD, 16'h000c);
        rd(DIS_REG_ALT_SPD, 16'h000c);
        #1 cmp16({run_origin, speed_origin}, 16'h040c);
        rd(DIS_REG_STATUS, 16'h0001);
        wr(DIS_REG_POLARITY, 16'h0002);
        repeat (200) @(posedge ref_clk);
        rd(DIS_REG_STATE, 16'h0003);
        wr(DIS_REG_ON_TIME, 16'h0000);
        wr(DIS_REG_DLY_SEL, 16'h0004);
        target[2] <= 1'b1;
        repeat (30) @(posedge ref_clk);
        #1 cmp16({11'h000, terminal_state_bits}, 16'h0007);
        glitch <= 5'h08;
        repeat (5) @(posedge ref_clk);
        glitch <= 5'h00;
        repeat (200) @(posedge ref_clk);
        #1 cmp16({11'h000, terminal_state_bits}, 16'h0007);
        target[0] <= 1'b0;
        wait_alt(1'b0);
        cmp16({15'h0000, n >= 2 * TICK}, 16'h0001);
        repeat (2) @(posedge ref_clk);
        #1 cmp16({15'h0000, run_command}, 16'h0001);
        end_sim();
    end
endmodule
